// ### bench/prio_bank_asserts.sv
// checker: bus and priority field assertions for the priority bank
`timescale 1ns/1ps
module prio_bank_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bus and levels
  input wire prio_bank_pkg::apb_req_t apb_req,
  input wire prio_bank_pkg::apb_rsp_t apb_rsp,
  input wire prio_bank_pkg::prio_levels_t levels,
  input wire logic [prio_bank_pkg::NUM_SRC-1:0] src_enabled
);
  import prio_bank_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire logic take = apb_req.psel && apb_req.penable && !apb_rsp.pready;
  wire logic rd_ok = apb_rsp.pready && !apb_req.pwrite && !apb_rsp.pslverr;
  wire logic wr_ok = apb_rsp.pready && apb_req.pwrite && !apb_rsp.pslverr;
  AST_ANSWER: assert property (take |=> apb_rsp.pready)
    else $error("access not answered next cycle");
  AST_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready longer than one cycle");
  AST_RESET: assert property ($past(srst) |-> levels == {18{3'h4}} && &src_enabled)
    else $error("levels not at reset value");
  AST_ENABLE: assert property (src_enabled[17] == (levels[53:51] != 3'h0))
    else $error("enable does not follow level");
  AST_TOP_ZERO: assert property (rd_ok && apb_req.paddr == OFS_CTRL_3
    |-> apb_rsp.prdata[31:11] == 21'h0)
    else $error("upper bits of register 3 not zero");
  AST_SEP: assert property (rd_ok |-> (apb_rsp.prdata & 32'hFFFF8888) == 32'h0)
    else $error("separator bit read nonzero");
  AST_WR7: assert property (wr_ok && apb_req.paddr == OFS_CTRL_7 && apb_req.pstrb[0]
    |-> levels.timer5_priority == apb_req.pwdata[2:0])
    else $error("written level not presented");
  AST_STILL: assert property (levels != $past(levels) |-> wr_ok || $past(srst))
    else $error("levels changed without a write");
  AST_REFUSE: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
    else $error("refusal without ready or with data");
endmodule // prio_bank_asserts
bind prio_bank prio_bank_asserts u_asserts (.clk(clk), .srst(srst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .levels(levels), .src_enabled(src_enabled));

// ### bench/tb_prio_bank.sv
// testbench: register access and level checks for the priority bank
`timescale 1ns/1ps
module tb_prio_bank;
  import prio_bank_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  prio_levels_t levels;
  logic [NUM_SRC-1:0] src_enabled;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int n_compared = 0;
  prio_bank u_dut (.clk(clk), .srst(srst), .apb_req(req), .apb_rsp(rsp), .levels(levels),
    .src_enabled(src_enabled));
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
    @(posedge clk);
    req.penable <= 1'b1;
    // wait for the answer however long it takes; only the watchdog ends a hang
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk("read data", {32'h0, exp}, {32'h0, rd});
  endtask
  task automatic close_out();
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rdchk(12'h000, 32'h0444);
    rdchk(12'h004, 32'h4044);
    for (int i = 2; i < 5; i++) rdchk(12'(4 * i), 32'h4444);
    rdchk(12'h000, 32'h0444);
    for (int i = 0; i < 5; i++) apb(1'b1, 12'(4 * i), 32'hFFFFFFFF, 4'hF);
    rdchk(12'h000, 32'h0777);
    rdchk(12'h004, 32'h7077);
    for (int i = 2; i < 5; i++) rdchk(12'(4 * i), 32'h7777);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h00C, {16'h0, {4{1'b0, 3'(c)}}}, 4'h3);
      chk("timer4 level", 64'(c), 64'(levels.timer4_priority));
      chk("timer4 enable", 64'(c != 0), 64'(src_enabled[7]));
    end
    apb(1'b1, 12'h000, 32'h0123, 4'hF);
    apb(1'b1, 12'h004, 32'h5067, 4'hF);
    apb(1'b1, 12'h008, 32'h1234, 4'hF);
    apb(1'b1, 12'h00C, 32'h4567, 4'hF);
    apb(1'b1, 12'h010, 32'h7654, 4'hF);
    chk("levels", 64'({3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4,
      3'h5, 3'h6, 3'h7, 3'h7, 3'h6, 3'h5, 3'h4}), 64'(levels));
    apb(1'b1, 12'h010, 32'h0, 4'h1);
    rdchk(12'h010, 32'h7600);
    apb(1'b1, 12'h014, 32'hFFFF, 4'hF);
    chk("unmapped error", 64'h1, 64'(er));
    rdchk(12'h010, 32'h7600);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("levels after reset", 64'({18{3'h4}}), 64'(levels));
    close_out();
  end
endmodule // tb_prio_bank

// ### core/prio_bank.sv
// priority register bank for interrupt sources, APB slave
`timescale 1ns/1ps
module prio_bank (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire prio_bank_pkg::apb_req_t apb_req,
  output prio_bank_pkg::apb_rsp_t apb_rsp,
  // levels to the arbitration logic
  output prio_bank_pkg::prio_levels_t levels,
  output logic [prio_bank_pkg::NUM_SRC-1:0] src_enabled
);
  import prio_bank_pkg::*;

  bank_state_t state;
  bank_state_t next_state;
  logic access;
  logic wr;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] wmask;

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge of write data

  always_comb begin
    wdata = apb_req.pwdata[REG_W-1:0];
    wmask = {{8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};
  end

  assign access = apb_req.psel & apb_req.penable & ~state.rsp.pready;
  assign wr = access & apb_req.pwrite;

  function automatic logic [REG_W-1:0] merge(
    input logic [REG_W-1:0] cur,
    input logic [REG_W-1:0] impl
  );
    // only implemented bits under an enabled byte lane change
    merge = (cur & ~(wmask & impl)) | (wdata & wmask & impl);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [NUM_SRC*LVL_W-1:0] flat;
    flat = '0;
    next_state = state;
    next_state.rsp.pready = access;
    next_state.rsp.pslverr = 1'b0;
    next_state.rsp.prdata = '0;
    if (access) begin
      case (apb_req.paddr)
        OFS_CTRL_3: begin
          if (wr) next_state.ctrl_3 = merge(state.ctrl_3, MASK_CTRL_3);
          next_state.rsp.prdata = {16'h0000, state.ctrl_3 & MASK_CTRL_3};
        end
        OFS_CTRL_4: begin
          if (wr) next_state.ctrl_4 = merge(state.ctrl_4, MASK_CTRL_4);
          next_state.rsp.prdata = {16'h0000, state.ctrl_4 & MASK_CTRL_4};
        end
        OFS_CTRL_5: begin
          if (wr) next_state.ctrl_5 = merge(state.ctrl_5, MASK_FULL);
          next_state.rsp.prdata = {16'h0000, state.ctrl_5 & MASK_FULL};
        end
        OFS_CTRL_6: begin
          if (wr) next_state.ctrl_6 = merge(state.ctrl_6, MASK_FULL);
          next_state.rsp.prdata = {16'h0000, state.ctrl_6 & MASK_FULL};
        end
        OFS_CTRL_7: begin
          if (wr) next_state.ctrl_7 = merge(state.ctrl_7, MASK_FULL);
          next_state.rsp.prdata = {16'h0000, state.ctrl_7 & MASK_FULL};
        end
        default: begin
          next_state.rsp.pslverr = 1'b1;
        end
      endcase
    end
    // unpack fields from the updated registers so levels follow writes at once
    next_state.levels.dma_ch1_done_priority = next_state.ctrl_3[POS_F2 +: LVL_W];
    next_state.levels.adc_a_done_priority = next_state.ctrl_3[POS_F1 +: LVL_W];
    next_state.levels.uart_a_tx_priority = next_state.ctrl_3[POS_F0 +: LVL_W];
    next_state.levels.pin_change_priority = next_state.ctrl_4[POS_F3 +: LVL_W];
    next_state.levels.i2c_a_master_priority = next_state.ctrl_4[POS_F1 +: LVL_W];
    next_state.levels.i2c_a_slave_priority = next_state.ctrl_4[POS_F0 +: LVL_W];
    next_state.levels.capture_ch8_priority = next_state.ctrl_5[POS_F3 +: LVL_W];
    next_state.levels.capture_ch7_priority = next_state.ctrl_5[POS_F2 +: LVL_W];
    next_state.levels.adc_b_done_priority = next_state.ctrl_5[POS_F1 +: LVL_W];
    next_state.levels.ext_irq1_priority = next_state.ctrl_5[POS_F0 +: LVL_W];
    next_state.levels.timer4_priority = next_state.ctrl_6[POS_F3 +: LVL_W];
    next_state.levels.compare_ch4_priority = next_state.ctrl_6[POS_F2 +: LVL_W];
    next_state.levels.compare_ch3_priority = next_state.ctrl_6[POS_F1 +: LVL_W];
    next_state.levels.dma_ch2_done_priority = next_state.ctrl_6[POS_F0 +: LVL_W];
    next_state.levels.uart_b_tx_priority = next_state.ctrl_7[POS_F3 +: LVL_W];
    next_state.levels.uart_b_rx_priority = next_state.ctrl_7[POS_F2 +: LVL_W];
    next_state.levels.ext_irq2_priority = next_state.ctrl_7[POS_F1 +: LVL_W];
    next_state.levels.timer5_priority = next_state.ctrl_7[POS_F0 +: LVL_W];
    // level code is the priority itself: 001 lowest .. 111 highest
    flat = next_state.levels;
    for (int i = 0; i < NUM_SRC; i++) begin
      next_state.src_enabled[i] = (flat[i*LVL_W +: LVL_W] != LVL_OFF);
    end
    if (srst) begin
      next_state.ctrl_3 = RESET_CTRL_3;
      next_state.ctrl_4 = RESET_CTRL_4;
      next_state.ctrl_5 = RESET_FULL;
      next_state.ctrl_6 = RESET_FULL;
      next_state.ctrl_7 = RESET_FULL;
      next_state.rsp = '0;
      next_state.levels = {NUM_SRC{LVL_RESET}};
      next_state.src_enabled = '1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign apb_rsp = state.rsp;
  assign levels = state.levels;
  assign src_enabled = state.src_enabled;

endmodule // prio_bank

// ### inc/prio_bank_pkg.sv
// package: register map, field layout and types of the priority bank
package prio_bank_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int LVL_W = 3;
  localparam int NUM_SRC = 18;
  // byte offsets (chosen; five aligned words)
  localparam logic [ADDR_W-1:0] OFS_CTRL_3 = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CTRL_4 = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CTRL_5 = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CTRL_6 = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_CTRL_7 = 12'h010;
  // field low bit positions
  localparam int POS_F3 = 12;
  localparam int POS_F2 = 8;
  localparam int POS_F1 = 4;
  localparam int POS_F0 = 0;
  // implemented-bit masks per register
  localparam logic [REG_W-1:0] MASK_CTRL_3 = 16'h0777;
  localparam logic [REG_W-1:0] MASK_CTRL_4 = 16'h7077;
  localparam logic [REG_W-1:0] MASK_FULL = 16'h7777;
  // every field loads 100 while srst is high
  localparam logic [LVL_W-1:0] LVL_RESET = 3'h4;
  localparam logic [LVL_W-1:0] LVL_OFF = 3'h0;
  localparam logic [REG_W-1:0] RESET_CTRL_3 = 16'h0444;
  localparam logic [REG_W-1:0] RESET_CTRL_4 = 16'h4044;
  localparam logic [REG_W-1:0] RESET_FULL = 16'h4444;

  typedef logic [LVL_W-1:0] level_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W/8-1:0] pstrb;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } apb_rsp_t;

  // levels in order: ctrl_3 f2,f1,f0; ctrl_4 f3,f1,f0; ctrl_5..7 f3..f0
  typedef struct packed {
    level_t dma_ch1_done_priority;
    level_t adc_a_done_priority;
    level_t uart_a_tx_priority;
    level_t pin_change_priority;
    level_t i2c_a_master_priority;
    level_t i2c_a_slave_priority;
    level_t capture_ch8_priority;
    level_t capture_ch7_priority;
    level_t adc_b_done_priority;
    level_t ext_irq1_priority;
    level_t timer4_priority;
    level_t compare_ch4_priority;
    level_t compare_ch3_priority;
    level_t dma_ch2_done_priority;
    level_t uart_b_tx_priority;
    level_t uart_b_rx_priority;
    level_t ext_irq2_priority;
    level_t timer5_priority;
  } prio_levels_t;

  typedef struct packed {
    logic [REG_W-1:0] ctrl_3;
    logic [REG_W-1:0] ctrl_4;
    logic [REG_W-1:0] ctrl_5;
    logic [REG_W-1:0] ctrl_6;
    logic [REG_W-1:0] ctrl_7;
    apb_rsp_t rsp;
    prio_levels_t levels;
    logic [NUM_SRC-1:0] src_enabled;
  } bank_state_t;
endpackage
